// *** verilog/sbg_pkg.sv ***
// package for the serial bit clock and baud generator block
// assumes a single 100 MHz clock with synchronous active-high reset
package sbg_pkg;

	// register bus widths
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned DIV_W  = 16;

	// register offsets
	localparam logic [2:0] REG_DIV_LO  = 3'h0; // divisor low byte, write resets, enables only after a high byte write
	localparam logic [2:0] REG_DIV_HI  = 3'h1; // divisor high byte, write resets
	localparam logic [2:0] REG_CLK_CFG = 3'h2; // clock_config_reg
	localparam logic [2:0] REG_SYNC_IN = 3'h3; // sync_input_control_reg
	localparam logic [2:0] REG_STATUS  = 3'h4; // read-only status

	// clock_config_reg field positions
	localparam int unsigned CCR_CD_BIT  = 0; // clock_divide_select
	localparam int unsigned CCR_XRX_BIT = 1; // ext_rx_clock_enable
	localparam int unsigned CCR_SLA_BIT = 2; // tx_clock_pin_select_a
	localparam int unsigned CCR_SLB_BIT = 3; // tx_clock_pin_select_b
	localparam int unsigned CCR_W       = 4;

	// sync_input_control_reg field positions
	localparam int unsigned SIC_SYNC_MODE_ENABLE_BIT = 0; // sync_mode_enable
	localparam int unsigned SIC_POL_BIT  = 1; // carrier active level
	localparam int unsigned SIC_W        = 2;

	// status field positions
	localparam int unsigned STS_RUN_BIT = 0;
	localparam int unsigned STS_LVL_BIT = 1;
	localparam int unsigned STS_CAR_BIT = 2;
	localparam int unsigned STS_EXP_BIT = 3;
	localparam int unsigned STS_STP_BIT = 4;

	// reset values
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [3:0]  CCR_RST = 4'h0;
	localparam logic [1:0]  SIC_RST = 2'h0;

	// divider limits and prescaler
	localparam logic [15:0] DIV_MIN      = 16'h0002;
	localparam logic [3:0]  PRESCALE_TOP = 4'hf; // divide by 16

	// reference rates of the bit clock section
	localparam int unsigned INTERNAL_CLOCK_REF_KHZ      = 24000;
	localparam int unsigned MAX_UNDIV_KBAUD     = 3000;
	localparam int unsigned MAX_DIV16_KBAUD     = 750;
	localparam int unsigned MAX_DIV16_EXT_KBAUD = 375;
	localparam int unsigned CLK_KHZ             = 100000;

	// synchroniser lanes
	localparam int unsigned SYNC_W     = 4;
	localparam int unsigned SYNC_SIN   = 0;
	localparam int unsigned SYNC_EXT_RECEIVE_CLOCK_IN = 1;
	localparam int unsigned SYNC_EXT_TRANSMIT_CLOCK_IN = 2;
	localparam int unsigned SYNC_DCD   = 3;

	// transmit clock pin uses, {select_b, select_a}
	localparam logic [1:0] PIN_TX_IN   = 2'b00; // transmit clock input
	localparam logic [1:0] PIN_BAUD    = 2'b01; // baud generator output
	localparam logic [1:0] PIN_SCLK    = 2'b10; // serial clock output
	localparam logic [1:0] PIN_SCLK_EX = 2'b11; // serial clock, expansion mode

	// initialisation sequencer
	typedef enum logic [3:0] {
		ST_OFF   = 4'b0001,
		ST_HI_WR = 4'b0010,
		ST_LO_WR = 4'b0100,
		ST_RUN   = 4'b1000
	} sbg_init_t;

	// register bus request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sbg_bus_req_t;

	// clock_config_reg
	typedef struct packed {
		logic tx_clock_pin_select_b;
		logic tx_clock_pin_select_a;
		logic ext_rx_clock_enable;
		logic clock_divide_select;
	} sbg_ccr_t;

	// sync_input_control_reg
	typedef struct packed {
		logic carrier_polarity;
		logic sync_mode_enable;
	} sbg_sync_input_control_reg_t;

	// main block state
	typedef struct packed {
		sbg_init_t   init;
		logic [15:0] divisor;
		sbg_ccr_t    clock_config_reg;
		sbg_sync_input_control_reg_t   sync_input_control_reg;
		logic [7:0]  rdata;
		logic [3:0]  rx_pre;
		logic [3:0]  tx_pre;
		logic        rx_clk_prev;
		logic        tx_clk_prev;
		logic        rx_bit_tick;
		logic        tx_bit_tick;
		logic        rx_data;
		logic        tx_pin_out;
		logic        tx_pin_oe;
		logic        txrx_enable;
		logic        txrx_reset;
		logic        serial_expansion;
		logic        carrier_active;
	} sbg_main_t;

	// divider state
	typedef struct packed {
		logic [15:0] cnt;
		logic        level;
		logic        rise;
	} sbg_div_t;

	// synchroniser state
	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] stable;
	} sbg_sync_t;

endpackage

// *** verilog/sbg_sync.sv ***
// two-flop synchroniser for the serial pins
// assumes asynchronous pin levels; first stage feeds only the second
`timescale 1ns/1ns
module sbg_sync (
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic [sbg_pkg::SYNC_W-1:0] pins,
	output logic      [sbg_pkg::SYNC_W-1:0] pins_sync
);
	import sbg_pkg::*;

	sbg_sync_t st_q; // both stages
	sbg_sync_t st_d; // next stages

	// shift pins through two stages
	always_comb begin
		st_d        = st_q;
		st_d.meta   = pins;
		st_d.stable = st_q.meta;
	end

	// register the stages
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pins_sync = st_q.stable;

endmodule

// *** verilog/sbg_divider.sv ***
// programmable divide-by-n counter with a clock-level output
// assumes in_tick is a one-cycle enable at the input clock rate
`timescale 1ns/1ns
module sbg_divider #(
	parameter int unsigned DIV_W = sbg_pkg::DIV_W
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             run,
	input  wire logic             in_tick,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  level,
	output logic                  rise
);
	import sbg_pkg::*;

	// the state struct is sized for the documented width
	if (DIV_W != 16) begin : g_width_check
		$error("sbg_divider supports only a 16-bit divisor");
	end

	sbg_div_t    st_q;     // counter, level and rise
	sbg_div_t    st_d;     // next state
	logic        valid;    // divisor may run
	logic [15:0] reload;   // divisor minus one
	logic [15:0] half_lo;  // ticks spent low per period

	// count down, reload at zero, level high in upper part
	always_comb begin
		st_d    = st_q;
		st_d.rise = 1'b0;
		valid   = (divisor >= DIV_MIN);
		reload  = divisor - 16'h0001;
		half_lo = {1'b0, divisor[15:1]};
		if (!run || !valid) begin
			// stopped: preload so the first count is exact
			st_d.cnt   = reload;
			st_d.level = 1'b0;
		end else if (in_tick) begin
			if (st_q.cnt == 16'h0000) begin
				st_d.cnt  = reload;
				st_d.rise = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - 16'h0001;
			end
			// output period is divisor input ticks
			st_d.level = (st_d.cnt >= half_lo);
		end
	end

	// register the counter
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.level;
	assign rise  = st_q.rise;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	stop_small_a: assert property (
		(divisor < DIV_MIN) |=> !level && !rise)
		else $error("divider runs with divisor below two");

	preload_a: assert property (
		!run |=> (st_q.cnt == 16'($past(divisor) - 16'h0001)))
		else $error("divisor not preloaded while stopped");

	reload_rise_a: assert property (
		rise |-> $past(st_q.cnt) == 16'h0000 && st_q.cnt == divisor - 16'h0001)
		else $error("rise without reload from zero");

endmodule

// *** verilog/sbg_core.sv ***
// bit clock and baud generator of the serial interface
// assumes a plain register port from software and asynchronous serial pins
`timescale 1ns/1ns
// Operation
// - divide by sixteen unless divide select set
// - internal clock reaches undivided and /16 maxima
// - external clock reaches lower /16 maximum
// - two select bits set transmit clock pin use
// - receive clock pin used only when enabled
// - sixteen-bit divider, divisors two to 65535
// - divisor loaded at once on initialisation; first period still counts the divisor from before the last byte write
// - output frequency is input over divisor
// - divisor zero or one stops the divider
// - generator output has even duty cycle for even divisors, high one tick longer for odd
// - internal clock may feed the generator
// - divisor byte write disables and resets all
// - second byte write restarts generator and paths
// - received data and clock synchronised internally
// - data input pin feeds the receiver
// - enabled receive clock pin drives generator
// - carrier gates receive clock in sync mode
// - sync mode enable bit picks sync mode
// - select eleven without sync means expansion mode
module sbg_core (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire sbg_pkg::sbg_bus_req_t bus_req,
	output logic [7:0]                 bus_rdata,
	input  wire logic                  serial_data_input,
	input  wire logic                  ext_receive_clock_in,
	input  wire logic                  ext_transmit_clock_in,
	input  wire logic                  carrier_detect_gate,
	output logic                       tx_clock_pin_out,
	output logic                       tx_clock_pin_oe,
	output logic                       rx_bit_tick,
	output logic                       tx_bit_tick,
	output logic                       rx_data,
	output logic                       txrx_enable,
	output logic                       txrx_reset,
	output logic                       serial_expansion
);
	import sbg_pkg::*;

	sbg_main_t          st_q;        // all block state
	sbg_main_t          st_d;        // next block state
	logic [SYNC_W-1:0]  pin_s;       // synchronised pin levels
	logic               div_level;   // generator output level
	logic               div_rise;    // generator period pulse
	logic               div_in_tick; // generator input clock enable
	logic               div_run;     // generator allowed to count
	logic               run_now;     // block enabled after this cycle
	logic               rx_edge;     // rising edge on receive clock pin
	logic               tx_edge;     // rising edge on transmit clock pin
	logic               car_act;     // carrier at its active level
	logic               rx_gate;     // receive clock allowed through
	logic               rx_raw;      // receive clock before prescale
	logic               tx_raw;      // transmit clock before prescale
	logic [1:0]         pin_sel;     // transmit clock pin use
	logic               tx_level;    // transmit bit clock level

	// next step of the init sequencer on a divisor byte write
	function automatic sbg_init_t next_init(input sbg_init_t cur, input logic is_hi);
		sbg_init_t nxt;
		nxt = cur;
		case (cur)
			ST_HI_WR: begin
				nxt = is_hi ? ST_HI_WR : ST_RUN;
			end
			ST_LO_WR: begin
				nxt = is_hi ? ST_RUN : ST_LO_WR;
			end
			default: begin
				// off or running: any byte write disables first
				nxt = is_hi ? ST_HI_WR : ST_LO_WR;
			end
		endcase
		return nxt;
	endfunction

	// one prescaler step: divide by sixteen or pass through
	function automatic logic [4:0] prescale(input logic [3:0] cnt, input logic raw,
			input logic undiv, input logic run);
		logic [3:0] nc;
		logic       tick;
		nc   = cnt;
		tick = 1'b0;
		if (!run) begin
			nc = 4'h0;
		end else if (raw) begin
			nc   = cnt + 4'h1;
			tick = undiv | (cnt == PRESCALE_TOP);
		end
		return {tick, nc};
	endfunction

	// pins pass two flops before anything reads them
	sbg_sync u_sync (
		.clk       (clk),
		.srst      (srst),
		.pins      ({carrier_detect_gate, ext_transmit_clock_in, ext_receive_clock_in, serial_data_input}),
		.pins_sync (pin_s)
	);

	// receive clock pin feeds the generator when enabled, else internal clock
	assign rx_edge     = pin_s[SYNC_EXT_RECEIVE_CLOCK_IN] & ~st_q.rx_clk_prev;
	assign tx_edge     = pin_s[SYNC_EXT_TRANSMIT_CLOCK_IN] & ~st_q.tx_clk_prev;
	assign div_in_tick = st_q.clock_config_reg.ext_rx_clock_enable ? rx_edge : 1'b1;
	assign div_run     = (st_q.init == ST_RUN);

	// sixteen-bit divide-by-n generator
	sbg_divider #(
		.DIV_W (DIV_W)
	) u_div (
		.clk     (clk),
		.srst    (srst),
		.run     (div_run),
		.in_tick (div_in_tick),
		.divisor (st_q.divisor),
		.level   (div_level),
		.rise    (div_rise)
	);

	// register port, sequencer, clock routing and prescalers
	always_comb begin
		logic [4:0] rx_ps;
		logic [4:0] tx_ps;
		rx_ps = 5'h00;
		tx_ps = 5'h00;
		st_d             = st_q;
		st_d.rdata       = 8'h00;
		st_d.txrx_reset  = 1'b0;
		st_d.rx_clk_prev = pin_s[SYNC_EXT_RECEIVE_CLOCK_IN];
		st_d.tx_clk_prev = pin_s[SYNC_EXT_TRANSMIT_CLOCK_IN];
		st_d.rx_data     = pin_s[SYNC_SIN];
		// register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				REG_DIV_LO: begin
					st_d.divisor[7:0] = bus_req.wdata;
					st_d.txrx_reset   = 1'b1;
					st_d.init         = next_init(st_q.init, 1'b0);
				end
				REG_DIV_HI: begin
					st_d.divisor[15:8] = bus_req.wdata;
					st_d.txrx_reset    = 1'b1;
					st_d.init          = next_init(st_q.init, 1'b1);
				end
				REG_CLK_CFG: begin
					st_d.clock_config_reg = bus_req.wdata[CCR_W-1:0];
				end
				REG_SYNC_IN: begin
					st_d.sync_input_control_reg = bus_req.wdata[SIC_W-1:0];
				end
				default: begin
					// unmapped writes are ignored
				end
			endcase
		end
		// register reads, data valid in the next cycle only
		if (bus_req.rd) begin
			case (bus_req.addr)
				REG_DIV_LO:  st_d.rdata = st_q.divisor[7:0];
				REG_DIV_HI:  st_d.rdata = st_q.divisor[15:8];
				REG_CLK_CFG: st_d.rdata = {4'h0, st_q.clock_config_reg};
				REG_SYNC_IN: st_d.rdata = {6'h00, st_q.sync_input_control_reg};
				REG_STATUS: begin
					st_d.rdata[STS_RUN_BIT] = (st_q.init == ST_RUN);
					st_d.rdata[STS_LVL_BIT] = div_level;
					st_d.rdata[STS_CAR_BIT] = st_q.carrier_active;
					st_d.rdata[STS_EXP_BIT] = st_q.serial_expansion;
					st_d.rdata[STS_STP_BIT] = (st_q.divisor < DIV_MIN);
				end
				default: st_d.rdata = 8'h00;
			endcase
		end
		// paths run only while the sequencer stays in run
		run_now          = (st_d.init == ST_RUN);
		st_d.txrx_enable = run_now;
		// carrier only matters in sync mode
		car_act             = (pin_s[SYNC_DCD] == st_q.sync_input_control_reg.carrier_polarity);
		st_d.carrier_active = car_act;
		rx_gate             = !st_q.sync_input_control_reg.sync_mode_enable || car_act;
		// receive and transmit clocks before the prescaler
		pin_sel = {st_q.clock_config_reg.tx_clock_pin_select_b, st_q.clock_config_reg.tx_clock_pin_select_a};
		rx_raw  = div_rise && rx_gate;
		tx_raw  = (pin_sel == PIN_TX_IN) ? tx_edge : div_rise;
		// sixteen-times or one-times bit clocks
		rx_ps            = prescale(st_q.rx_pre, rx_raw, st_q.clock_config_reg.clock_divide_select, run_now);
		tx_ps            = prescale(st_q.tx_pre, tx_raw, st_q.clock_config_reg.clock_divide_select, run_now);
		st_d.rx_pre      = rx_ps[3:0];
		st_d.tx_pre      = tx_ps[3:0];
		st_d.rx_bit_tick = rx_ps[4];
		st_d.tx_bit_tick = tx_ps[4];
		// transmit clock pin use
		tx_level = st_q.clock_config_reg.clock_divide_select ? div_level : st_q.tx_pre[3];
		case (pin_sel)
			PIN_TX_IN: begin
				st_d.tx_pin_oe  = 1'b0;
				st_d.tx_pin_out = 1'b0;
			end
			PIN_BAUD: begin
				st_d.tx_pin_oe  = 1'b1;
				st_d.tx_pin_out = div_level;
			end
			default: begin
				st_d.tx_pin_oe  = 1'b1;
				st_d.tx_pin_out = tx_level && run_now;
			end
		endcase
		// expansion mode needs sync mode off
		st_d.serial_expansion = !st_q.sync_input_control_reg.sync_mode_enable && (pin_sel == PIN_SCLK_EX);
	end

	// register all state
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q         <= '0;
			st_q.init    <= ST_OFF;
			st_q.divisor <= DIV_RST;
			st_q.clock_config_reg     <= CCR_RST;
			st_q.sync_input_control_reg    <= SIC_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	assign bus_rdata        = st_q.rdata;
	assign tx_clock_pin_out = st_q.tx_pin_out;
	assign tx_clock_pin_oe  = st_q.tx_pin_oe;
	assign rx_bit_tick      = st_q.rx_bit_tick;
	assign tx_bit_tick      = st_q.tx_bit_tick;
	assign rx_data          = st_q.rx_data;
	assign txrx_enable      = st_q.txrx_enable;
	assign txrx_reset       = st_q.txrx_reset;
	assign serial_expansion = st_q.serial_expansion;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	write_disables_a: assert property (
		(bus_req.wr && (bus_req.addr == REG_DIV_LO || bus_req.addr == REG_DIV_HI) && st_q.init != ST_HI_WR
			&& st_q.init != ST_LO_WR) |=> !txrx_enable && txrx_reset)
		else $error("divisor write did not disable the paths");

	pair_enables_a: assert property (
		(st_q.init == ST_HI_WR && bus_req.wr && bus_req.addr == REG_DIV_LO) |=> txrx_enable ##1 div_run)
		else $error("second divisor byte did not enable");

	div16_tick_a: assert property (
		(run_now && !st_q.clock_config_reg.clock_divide_select && rx_raw && st_q.rx_pre == PRESCALE_TOP) |=> rx_bit_tick)
		else $error("sixteenth receive clock did not tick");

	div16_hold_a: assert property (
		(!st_q.clock_config_reg.clock_divide_select && st_q.rx_pre != PRESCALE_TOP) |=> !rx_bit_tick)
		else $error("divided receive tick came early");

	carrier_block_a: assert property (
		(st_q.sync_input_control_reg.sync_mode_enable && !car_act) |=> !rx_bit_tick)
		else $error("receive clock passed without carrier");

	pin_input_a: assert property (
		(pin_sel == PIN_TX_IN) |=> !tx_clock_pin_oe)
		else $error("transmit clock pin driven while input");

	data_path_a: assert property (
		(!$past(srst, 1) && !$past(srst, 2) && !$past(srst, 3)) |-> rx_data == $past(serial_data_input, 3))
		else $error("serial data input not passed to receiver");

	expansion_mode_a: assert property (
		(pin_sel == PIN_SCLK_EX && !st_q.sync_input_control_reg.sync_mode_enable) |=> serial_expansion)
		else $error("expansion mode not flagged");

	read_once_a: assert property (
		!$past(bus_req.rd) |-> bus_rdata == 8'h00)
		else $error("read data outside the answer cycle");

endmodule

// *** verification/sbg_peer_model.sv ***
// serial peer model: drives data, carrier and the two external bit clocks
// assumes the bench sets run, half period and levels just after a rising edge
`timescale 1ns/1ns
module sbg_peer_model (
	input  wire logic       clk,
	input  wire logic       rx_run,
	input  wire logic       tx_run,
	input  wire logic [3:0] half,
	input  wire logic       data_lvl,
	input  wire logic       carrier_lvl,
	output logic            serial_data_input,
	output logic            ext_receive_clock_in,
	output logic            ext_transmit_clock_in,
	output logic            carrier_detect_gate
);
	logic [3:0] rx_cnt_q; // receive clock half-period count
	logic [3:0] tx_cnt_q; // transmit clock half-period count
	logic       rx_go_q;  // receive clock held back one cycle after run

	// data and carrier follow the bench levels on the same edge as the clocks
	assign serial_data_input   = data_lvl;
	assign carrier_detect_gate = carrier_lvl;

	initial begin
		ext_receive_clock_in  = 1'b0;
		ext_transmit_clock_in = 1'b0;
		rx_cnt_q              = 4'h0;
		tx_cnt_q              = 4'h0;
		rx_go_q               = 1'b0;
	end

	// clocks stand still at 0 outside frames; equal halves of at least two cycles
	always @(posedge clk) begin
		rx_go_q <= rx_run; // carrier is up a cycle before the first edge
		if (!rx_run) begin
			ext_receive_clock_in <= 1'b0;
			rx_cnt_q             <= 4'h0;
		end else if (rx_go_q) begin
			rx_cnt_q <= (rx_cnt_q == half - 4'h1) ? 4'h0 : rx_cnt_q + 4'h1;
			if (rx_cnt_q == half - 4'h1) begin
				ext_receive_clock_in <= !ext_receive_clock_in;
			end
		end
		if (!tx_run) begin
			ext_transmit_clock_in <= 1'b0;
			tx_cnt_q              <= 4'h0;
		end else begin
			tx_cnt_q <= (tx_cnt_q == half - 4'h1) ? 4'h0 : tx_cnt_q + 4'h1;
			if (tx_cnt_q == half - 4'h1) begin
				ext_transmit_clock_in <= !ext_transmit_clock_in;
			end
		end
	end
endmodule

// *** verification/test_sbg_core.sv ***
// self-checking bench for the bit clock and baud generator
// assumes sbg_pkg is compiled first and the peer model drives the pins
`timescale 1ns/1ns
module test_sbg_core;
	import sbg_pkg::*;
	logic         clk;
	logic         srst;
	sbg_bus_req_t bus_req;
	logic [7:0]   bus_rdata;
	logic         sdi, rxc, txc, dcd;
	logic         pin_out, pin_oe, rx_bit_tick, tx_bit_tick, rx_data, txrx_enable, txrx_reset, serial_expansion;
	logic         rx_run, tx_run, data_lvl, carrier_lvl;
	logic [3:0]   half;
	int           fails, checks, cycles;

	sbg_core u_sbg_core (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.serial_data_input(sdi), .ext_receive_clock_in(rxc), .ext_transmit_clock_in(txc),
		.carrier_detect_gate(dcd), .tx_clock_pin_out(pin_out), .tx_clock_pin_oe(pin_oe),
		.rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick), .rx_data(rx_data),
		.txrx_enable(txrx_enable), .txrx_reset(txrx_reset), .serial_expansion(serial_expansion));
	sbg_peer_model u_sbg_peer_model (.clk(clk), .rx_run(rx_run), .tx_run(tx_run), .half(half),
		.data_lvl(data_lvl), .carrier_lvl(carrier_lvl), .serial_data_input(sdi),
		.ext_receive_clock_in(rxc), .ext_transmit_clock_in(txc), .carrier_detect_gate(dcd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard: the whole run needs far fewer cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one-cycle register write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask

	// one-cycle read; data is taken in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = bus_rdata;
	endtask

	// high byte, configuration, then low byte to start; a full restart except from ST_LO_WR, where it ends disabled
	task automatic init(input logic [15:0] dv, input logic [7:0] cfg, input logic [7:0] sic);
		wr(REG_DIV_HI, dv[15:8]);
		wr(REG_CLK_CFG, cfg);
		wr(REG_SYNC_IN, sic);
		wr(REG_DIV_LO, dv[7:0]);
	endtask

	// cycles between two bit ticks; 200 means none seen
	task automatic gap(input bit rx, output int n);
		n = 0;
		do begin @(posedge clk); #1 n++; end while (!(rx ? rx_bit_tick : tx_bit_tick) && n < 200);
		n = 0;
		do begin @(posedge clk); #1 n++; end while (!(rx ? rx_bit_tick : tx_bit_tick) && n < 200);
	endtask

	// outputs idle, status shows a stopped divider, unmapped reads give zero
	task automatic t_reset();
		logic [7:0] d;
		#1 check({pin_oe, pin_out, rx_bit_tick, tx_bit_tick, rx_data, txrx_enable, txrx_reset, serial_expansion}, 0);
		rd(REG_STATUS, d);
		check(d, 8'h14);
		rd(3'h5, d);
		check(d, 8'h00);
		@(posedge clk);
		#1 check(bus_rdata, 8'h00);
	endtask

	// byte writes disable and pulse reset; the other byte re-enables
	task automatic t_seq();
		wr(REG_DIV_HI, 8'h00);
		#1 check({txrx_enable, txrx_reset}, 2'b01);
		wr(REG_DIV_HI, 8'h00);
		#1 check({txrx_enable, txrx_reset}, 2'b01);
		wr(REG_DIV_LO, 8'h02);
		#1 check({txrx_enable, txrx_reset}, 2'b11);
		wr(REG_DIV_LO, 8'h02);
		#1 check({txrx_enable, txrx_reset}, 2'b01);
		wr(REG_DIV_LO, 8'h02);
		#1 check(txrx_enable, 1'b0);
		wr(REG_DIV_HI, 8'h00);
		#1 check(txrx_enable, 1'b1);
	endtask

	// internal clock over divisors, undivided and by sixteen
	task automatic t_rate();
		int n;
		int dv[4] = '{2, 5, 7, 2};
		int ex[4] = '{2, 5, 7, 32};
		for (int i = 0; i < 4; i++) begin
			init(16'(dv[i]), (i == 3) ? 8'h04 : 8'h05, 8'h00);
			gap(1'b1, n);
			check(n, ex[i]);
			gap(1'b0, n);
			check(n, ex[i]);
		end
	endtask

	// generator level on the pin: high ceil(n/2) of every n cycles
	task automatic t_duty();
		int hi;
		for (int dv = 5; dv < 7; dv++) begin
			init(16'(dv), 8'h05, 8'h00);
			repeat (10) @(posedge clk);
			hi = 0;
			repeat (30) begin @(posedge clk); #1 hi += (pin_out === 1'b1); end
			check(hi, (dv == 5) ? 18 : 15);
			check(pin_oe, 1'b1);
		end
	endtask

	// divisors zero and one stop the generator
	task automatic t_stop();
		int n;
		logic [7:0] d;
		for (int dv = 0; dv < 2; dv++) begin
			init(16'(dv), 8'h05, 8'h00);
			gap(1'b1, n);
			check(n, 200);
			rd(REG_STATUS, d);
			check(d & 8'h10, 8'h10);
		end
	endtask

	// receive pin feeds the generator only when enabled
	task automatic t_ext();
		int n;
		half <= 4'h2;
		init(16'h0002, 8'h03, 8'h00);
		rx_run <= 1'b1;
		gap(1'b1, n);
		check(n, 8);
		gap(1'b0, n);
		check(n, 200);
		init(16'h0002, 8'h01, 8'h00);
		gap(1'b1, n);
		check(n, 2);
		rx_run <= 1'b0;
		half   <= 4'h3;
		tx_run <= 1'b1;
		gap(1'b0, n);
		check(n, 6);
		check(pin_oe, 1'b0);
		tx_run <= 1'b0;
	endtask

	// carrier gates the receive ticks in sync mode at either active level
	task automatic t_sync();
		int n;
		carrier_lvl <= 1'b0;
		init(16'h0002, 8'h05, 8'h03);
		gap(1'b1, n);
		check(n, 200);
		gap(1'b0, n);
		check(n, 2);
		carrier_lvl <= 1'b1;
		gap(1'b1, n);
		check(n, 2);
		init(16'h0002, 8'h05, 8'h01);
		gap(1'b1, n);
		check(n, 200);
		init(16'h0002, 8'h05, 8'h00);
		gap(1'b1, n);
		check(n, 2);
	endtask

	// data pin reaches the receiver three cycles later; expansion mode flag
	task automatic t_pins();
		logic [7:0] d;
		@(posedge clk);
		data_lvl <= 1'b1;
		repeat (2) @(posedge clk);
		#1 check(rx_data, 1'b0);
		@(posedge clk);
		#1 check(rx_data, 1'b1);
		init(16'h0002, 8'h0d, 8'h00);
		#1 check(serial_expansion, 1'b1);
		rd(REG_STATUS, d);
		check(d & 8'h08, 8'h08);
		init(16'h0002, 8'h0d, 8'h01);
		#1 check(serial_expansion, 1'b0);
	endtask

	initial begin
		srst        = 1'b1;
		bus_req     = '0;
		rx_run      = 1'b0;
		tx_run      = 1'b0;
		half        = 4'h2;
		data_lvl    = 1'b0;
		carrier_lvl = 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_seq();
		t_rate();
		t_duty();
		t_stop();
		t_ext();
		t_sync();
		t_pins();
		report_and_stop();
	end
endmodule
